// ### qte_regs.vh
// Register map, field positions, reset values and timing figures
// for the qualified trigger engine.
// Assumes a 125 MHz core clock and a byte-addressed APB bus.
`ifndef QTE_REGS_VH
`define QTE_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define QTE_OFS_CTRL 8'h00
`define QTE_OFS_PATTERN 8'h04
`define QTE_OFS_LIMA_LO 8'h08
`define QTE_OFS_LIMA_HI 8'h0c
`define QTE_OFS_LIMB_LO 8'h10
`define QTE_OFS_LIMB_HI 8'h14
`define QTE_OFS_EVENTS 8'h18
`define QTE_OFS_STATUS 8'h1c

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define QTE_CTRL_EN 0
`define QTE_CTRL_METH_LO 1
`define QTE_CTRL_METH_HI 2
`define QTE_CTRL_QUAL_LO 3
`define QTE_CTRL_QUAL_HI 5
`define QTE_CTRL_SLOPE 6
`define QTE_CTRL_SRC_LO 7
`define QTE_CTRL_SRC_HI 8
`define QTE_CTRL_EXIT 9
`define QTE_CTRL_RST 32'h0000_0040

// ------------------------------------------------------------
// Methods, qualifications, pattern channel codes
// ------------------------------------------------------------
`define QTE_M_SINGLE 2'h0
`define QTE_M_PATTERN 2'h1
`define QTE_M_STATE 2'h2
`define QTE_M_TIME 2'h3
`define QTE_Q_HOLD_T 3'h0
`define QTE_Q_HOLD_E 3'h1
`define QTE_Q_INT_LT 3'h2
`define QTE_Q_INT_GT 3'h3
`define QTE_Q_PW_LT 3'h4
`define QTE_Q_PW_GT 3'h5
`define QTE_Q_TBP_LT 3'h6
`define QTE_Q_TBP_GT 3'h7
`define QTE_PAT_X 2'h0
`define QTE_PAT_H 2'h1
`define QTE_PAT_L 2'h2

// ------------------------------------------------------------
// Timing figures and derived cycle counts
// ------------------------------------------------------------
`define QTE_CLK_NS 8
`define QTE_TMIN_HOLD_NS 30
`define QTE_TMIN_WIN_NS 10
`define QTE_TMIN_PW_NS 1
`define QTE_TMAX_S 40'd680
`define QTE_NS_PER_S 40'd1000000000
`define QTE_CYC_UP(ns) (((ns) + `QTE_CLK_NS - 1) / `QTE_CLK_NS)
`define QTE_TMAX_CYC (`QTE_TMAX_S * `QTE_NS_PER_S / `QTE_CLK_NS)
`define QTE_EV_MAX 24'd15000000
`define QTE_TW 40
`define QTE_EW 24

`endif

// ### qte_sync.v
// Two-stage synchroniser for the comparator level inputs.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module qte_sync #(
   parameter W = 4
) (
   input wire core_clk, // Core clock
   input wire rst, // Synchronous reset, active high
   input wire [W-1:0] asyncIn, // Raw pin levels
   output wire [W-1:0] syncOut // Levels safe for core logic
);
   // ------------------------------------------------------------
   // Per-bit flop pairs
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg stage1_reg; // Only read by stage2
         reg stage2_reg; // Settled level
         // Second flop hides metastability of the first
         always @(posedge core_clk) begin
            if (rst) begin
               stage1_reg <= 1'b0;
               stage2_reg <= 1'b0;
            end else begin
               stage1_reg <= asyncIn[i];
               stage2_reg <= stage1_reg;
            end
         end
         assign syncOut[i] = stage2_reg;
      end
   endgenerate
endmodule // qte_sync

// ### qte_timer.v
// Saturating elapsed-time counter used for every time qualification.
// Assumes the caller restarts it synchronously with a one-cycle strobe.
`timescale 1ns/1ps
module qte_timer #(
   parameter W = 40,
   parameter [W-1:0] SAT = {W{1'b1}}
) (
   input wire core_clk, // Core clock
   input wire rst, // Synchronous reset, active high
   input wire restart, // Reload to zero
   output wire [W-1:0] elapsed // Cycles since last restart
);
   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   reg [W-1:0] count_reg; // Elapsed cycles
   // Saturate so a long idle never wraps into a false short reading
   always @(posedge core_clk) begin
      if (rst || restart) begin
         count_reg <= {W{1'b0}};
      end else if (count_reg != SAT) begin
         count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign elapsed = count_reg;
endmodule // qte_timer

// ### qte_engine.v
// Qualified trigger engine: turns comparator levels into one trigger pulse
// after edge, pattern, time and event-count qualification.
// Assumes comparator levels arrive asynchronously and APB runs on core_clk.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "qte_regs.vh"
module qte_engine #(
   parameter NCH = 4,
   parameter [`QTE_TW-1:0] TMAX_CYC = `QTE_TMAX_CYC,
   parameter [`QTE_EW-1:0] EV_MAX = `QTE_EV_MAX
) (
   input wire core_clk, // 125 MHz core clock
   input wire rst, // Synchronous reset, active high
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB direction
   input wire [7:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error for unmapped address
   input wire [NCH-1:0] compIn, // Comparator levels, above trigger level
   output reg trigOut // Trigger pulse to acquisition
);
   // ------------------------------------------------------------
   // Derived cycle limits
   // ------------------------------------------------------------
   localparam [`QTE_TW-1:0] MIN_HOLD = `QTE_CYC_UP(`QTE_TMIN_HOLD_NS);
   localparam [`QTE_TW-1:0] MIN_WIN = `QTE_CYC_UP(`QTE_TMIN_WIN_NS);
   localparam [`QTE_TW-1:0] MIN_PW = `QTE_CYC_UP(`QTE_TMIN_PW_NS);
   localparam [31:0] CTRL_RST = `QTE_CTRL_RST; // Control reset image, bit-selectable

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   reg en_reg; // Engine running
   reg [1:0] method_reg; // Selected method
   reg [2:0] qual_reg; // Selected qualification
   reg slopePos_reg; // 1 = positive slope
   reg [1:0] srcSel_reg; // Trigger source channel
   reg patExit_reg; // Pattern edge: 1 = exiting
   reg [2*NCH-1:0] patCfg_reg; // Two bits per channel
   reg [`QTE_TW-1:0] limA_reg; // Primary time limit, cycles
   reg [`QTE_TW-1:0] limB_reg; // Before limit, cycles, 0 = none
   reg [`QTE_EW-1:0] evN_reg; // Event setting

   // ------------------------------------------------------------
   // Engine state
   // ------------------------------------------------------------
   reg [NCH-1:0] compD_reg; // Previous synced levels
   reg patD_reg; // Previous pattern state
   reg [`QTE_EW-1:0] evCnt_reg; // Events since restart
   reg seen_reg; // Timed reference edge captured
   reg armed_reg; // Time qualified window open
   reg [15:0] trigCnt_reg; // Triggers issued
   wire [NCH-1:0] compS; // Synced comparator levels
   wire [`QTE_TW-1:0] elapsed; // Timer reading
   wire [NCH-1:0] chMatch; // Per-channel pattern match

   // ------------------------------------------------------------
   // Input synchroniser and timer
   // ------------------------------------------------------------
   qte_sync #(
      .W(NCH)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(compIn),
      .syncOut(compS)
   );

   reg tmrRestart; // Restart strobe from qualifier
   qte_timer #(
      .W(`QTE_TW),
      .SAT(TMAX_CYC)
   ) u_timer (
      .core_clk(core_clk),
      .rst(rst),
      .restart(tmrRestart),
      .elapsed(elapsed)
   );

   // ------------------------------------------------------------
   // Source edges and pattern recognition
   // ------------------------------------------------------------
   wire srcNow = compS[srcSel_reg]; // Source level
   wire srcWas = compD_reg[srcSel_reg]; // Source one cycle back
   wire riseEv = srcNow & ~srcWas; // Crossed above level
   wire fallEv = ~srcNow & srcWas; // Crossed below level
   wire selEdge = slopePos_reg ? riseEv : fallEv;
   wire oppEdge = slopePos_reg ? fallEv : riseEv;

   // Each channel demands high, low or nothing
   genvar c;
   generate
      for (c = 0; c < NCH; c = c + 1) begin : g_pat
         wire [1:0] code = patCfg_reg[2*c+1:2*c];
         assign chMatch[c] = (code == `QTE_PAT_H) ? compS[c] :
            (code == `QTE_PAT_L) ? ~compS[c] : 1'b1;
      end
   endgenerate
   wire patNow = &chMatch;
   wire patEnter = patNow & ~patD_reg; // Pattern begins
   wire patLeave = ~patNow & patD_reg; // Pattern ends

   // ------------------------------------------------------------
   // Effective limits, clamped to documented ranges
   // ------------------------------------------------------------
   reg [`QTE_TW-1:0] minA; // Floor for limit A
   reg [`QTE_TW-1:0] limA; // Clamped limit A
   reg [`QTE_TW-1:0] limB; // Clamped limit B
   reg [`QTE_EW-1:0] evN; // Clamped event setting
   always @* begin
      // Holdoff and interval floor is coarser than width floor
      if (method_reg == `QTE_M_STATE || method_reg == `QTE_M_TIME) begin
         minA = MIN_WIN;
      end else if (qual_reg <= `QTE_Q_INT_GT) begin
         minA = MIN_HOLD;
      end else begin
         minA = MIN_PW;
      end
      limA = (limA_reg < minA) ? minA :
         (limA_reg > TMAX_CYC) ? TMAX_CYC : limA_reg;
      limB = (limB_reg > TMAX_CYC) ? TMAX_CYC : limB_reg;
      evN = (evN_reg > EV_MAX) ? EV_MAX : evN_reg;
   end

   // ------------------------------------------------------------
   // Qualification decision
   // ------------------------------------------------------------
   reg evA; // Candidate trigger edge
   reg evB; // Width or gap start edge
   reg fire; // Trigger decision this cycle
   reg cntInc; // Count one event
   reg cntClr; // Restart event count
   reg seenSet; // Reference edge seen
   reg seenClr; // Reference consumed
   reg armSet; // Open time qualified window
   wire qLess = (qual_reg == `QTE_Q_INT_LT) || (qual_reg == `QTE_Q_PW_LT) ||
      (qual_reg == `QTE_Q_TBP_LT); // Less-than flavour
   wire inWin = (elapsed >= limA) && ((limB == {`QTE_TW{1'b0}}) || (elapsed < limB));
   always @* begin
      evA = 1'b0;
      evB = 1'b0;
      fire = 1'b0;
      cntInc = 1'b0;
      cntClr = 1'b0;
      seenSet = 1'b0;
      seenClr = 1'b0;
      armSet = 1'b0;
      tmrRestart = ~en_reg;
      case (method_reg)
         `QTE_M_SINGLE, `QTE_M_PATTERN: begin
            // Pick edges; single source uses the selected source edge and its opposite
            if (method_reg == `QTE_M_SINGLE) begin
               evA = selEdge;
               evB = oppEdge;
            end else if (qual_reg == `QTE_Q_PW_LT || qual_reg == `QTE_Q_PW_GT) begin
               evA = patLeave;
               evB = patEnter;
            end else if (qual_reg[2:1] == 2'h3) begin
               evA = patEnter;
               evB = patLeave;
            end else begin
               evA = patExit_reg ? patLeave : patEnter;
            end
            case (qual_reg)
               `QTE_Q_HOLD_T: begin
                  // Timer runs from the last trigger or enable
                  fire = evA && (elapsed >= limA);
                  if (fire) begin
                     tmrRestart = 1'b1;
                  end
               end
               `QTE_Q_HOLD_E: begin
                  // N counted events pass, the next one fires
                  fire = evA && (evCnt_reg >= evN);
                  cntInc = evA && !fire;
                  cntClr = fire;
               end
               `QTE_Q_INT_LT, `QTE_Q_INT_GT: begin
                  // Every selected edge both tests and restarts
                  fire = evA && seen_reg &&
                     (qLess ? (elapsed < limA) : (elapsed > limA));
                  if (evA) begin
                     tmrRestart = 1'b1;
                  end
                  seenSet = evA;
               end
               default: begin
                  // Width or gap: start edge restarts, end edge tests
                  fire = evA && seen_reg &&
                     (qLess ? (elapsed < limA) : (elapsed > limA));
                  if (evB) begin
                     tmrRestart = 1'b1;
                  end
                  seenSet = evB;
                  seenClr = evA;
               end
            endcase
         end
         `QTE_M_STATE: begin
            // Pattern only qualifies; the source edge fires
            if (patEnter) begin
               tmrRestart = 1'b1;
            end
            cntClr = patEnter;
            if (qual_reg[0]) begin
               fire = selEdge && patNow && (evCnt_reg + 1'b1 == evN);
               cntInc = selEdge && patNow && !fire;
            end else begin
               fire = selEdge && patNow && inWin;
            end
         end
         `QTE_M_TIME: begin
            // Window opens at entry and stays open after exit
            if (patEnter) begin
               tmrRestart = 1'b1;
            end
            armSet = patEnter;
            cntClr = patEnter;
            if (qual_reg[0]) begin
               fire = selEdge && armed_reg && (evCnt_reg == evN);
               cntInc = selEdge && armed_reg && !fire;
            end else begin
               fire = selEdge && armed_reg && inWin;
            end
         end
         default: begin
            fire = 1'b0;
         end
      endcase
      if (!en_reg) begin
         fire = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Engine state update
   // ------------------------------------------------------------
   // Disabled engine holds event count, reference and window cleared so a fresh start is clean
   always @(posedge core_clk) begin
      if (rst) begin
         compD_reg <= {NCH{1'b0}};
         patD_reg <= 1'b0;
         evCnt_reg <= {`QTE_EW{1'b0}};
         seen_reg <= 1'b0;
         armed_reg <= 1'b0;
         trigOut <= 1'b0;
         trigCnt_reg <= 16'h0000;
      end else begin
         compD_reg <= compS;
         patD_reg <= patNow;
         trigOut <= fire;
         if (!en_reg) begin
            evCnt_reg <= {`QTE_EW{1'b0}};
            seen_reg <= 1'b0;
            armed_reg <= 1'b0;
         end else begin
            // Clear outranks count since they never coincide usefully
            if (cntClr) begin
               evCnt_reg <= {`QTE_EW{1'b0}};
            end else if (cntInc && evCnt_reg != EV_MAX) begin
               evCnt_reg <= evCnt_reg + 1'b1;
            end
            // A new reference edge wins over consumption
            if (seenSet) begin
               seen_reg <= 1'b1;
            end else if (seenClr) begin
               seen_reg <= 1'b0;
            end
            // Re-entry reopens the window even on a trigger cycle
            if (armSet) begin
               armed_reg <= 1'b1;
            end else if (fire) begin
               armed_reg <= 1'b0;
            end
            if (fire) begin
               trigCnt_reg <= trigCnt_reg + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   wire mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0); // Eight words
   wire access = psel && penable; // Access phase
   wire wrDo = access && pready && pwrite && mapped; // Write commits
   wire cfgOk = !en_reg; // Settings only while idle
   reg [31:0] rdMux; // Read data selection
   always @* begin
      case (paddr)
         `QTE_OFS_CTRL: rdMux = {22'h0, patExit_reg, srcSel_reg, slopePos_reg,
            qual_reg, method_reg, en_reg};
         `QTE_OFS_PATTERN: rdMux = {{(32-2*NCH){1'b0}}, patCfg_reg};
         `QTE_OFS_LIMA_LO: rdMux = limA_reg[31:0];
         `QTE_OFS_LIMA_HI: rdMux = {24'h0, limA_reg[39:32]};
         `QTE_OFS_LIMB_LO: rdMux = limB_reg[31:0];
         `QTE_OFS_LIMB_HI: rdMux = {24'h0, limB_reg[39:32]};
         `QTE_OFS_EVENTS: rdMux = {8'h0, evN_reg};
         `QTE_OFS_STATUS: rdMux = {trigCnt_reg, 11'h0, armed_reg, seen_reg,
            srcNow, patNow, en_reg};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // One wait state: ready rises on the second access cycle
   always @(posedge core_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
         if (access && !pready) begin
            prdata <= (mapped && !pwrite) ? rdMux : 32'h0000_0000;
         end
      end
   end

   // Register writes; setting writes ignored while running
   always @(posedge core_clk) begin
      if (rst) begin
         en_reg <= CTRL_RST[`QTE_CTRL_EN];
         method_reg <= `QTE_M_SINGLE;
         qual_reg <= `QTE_Q_HOLD_T;
         slopePos_reg <= CTRL_RST[`QTE_CTRL_SLOPE];
         srcSel_reg <= 2'h0;
         patExit_reg <= 1'b0;
         patCfg_reg <= {(2*NCH){1'b0}};
         limA_reg <= MIN_HOLD;
         limB_reg <= {`QTE_TW{1'b0}};
         evN_reg <= 24'h000001;
      end else if (wrDo) begin
         case (paddr)
            `QTE_OFS_CTRL: begin
               en_reg <= pwdata[`QTE_CTRL_EN];
               if (cfgOk) begin
                  method_reg <= pwdata[`QTE_CTRL_METH_HI:`QTE_CTRL_METH_LO];
                  qual_reg <= pwdata[`QTE_CTRL_QUAL_HI:`QTE_CTRL_QUAL_LO];
                  slopePos_reg <= pwdata[`QTE_CTRL_SLOPE];
                  srcSel_reg <= pwdata[`QTE_CTRL_SRC_HI:`QTE_CTRL_SRC_LO];
                  patExit_reg <= pwdata[`QTE_CTRL_EXIT];
               end
            end
            `QTE_OFS_PATTERN: if (cfgOk) patCfg_reg <= pwdata[2*NCH-1:0];
            `QTE_OFS_LIMA_LO: if (cfgOk) limA_reg[31:0] <= pwdata;
            `QTE_OFS_LIMA_HI: if (cfgOk) limA_reg[39:32] <= pwdata[7:0];
            `QTE_OFS_LIMB_LO: if (cfgOk) limB_reg[31:0] <= pwdata;
            `QTE_OFS_LIMB_HI: if (cfgOk) limB_reg[39:32] <= pwdata[7:0];
            `QTE_OFS_EVENTS: if (cfgOk) evN_reg <= pwdata[23:0];
            default: begin
               en_reg <= en_reg; // Status is read only
            end
         endcase
      end
   end
endmodule // qte_engine

// ### qte_engine_properties.sv
// Concurrent checks on the trigger engine ports.
// Assumes one core clock domain and synchronous active-high reset.
`timescale 1ns/1ps
module qte_engine_checker #(
   parameter NCH = 4
) (
   input wire core_clk, // Core clock
   input wire rst, // Synchronous reset
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB direction
   input wire [7:0] paddr, // APB address
   input wire [31:0] pwdata, // APB write data
   input wire [31:0] prdata, // APB read data
   input wire pready, // APB ready
   input wire pslverr, // APB error
   input wire [NCH-1:0] compIn, // Comparator levels
   input wire trigOut // Trigger pulse
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic enShadow; // Last enable written over APB
   logic [3:0] disCnt; // Cycles spent disabled, saturating
   logic [3:0] quietCnt; // Cycles since comparator change
   logic [NCH-1:0] compPrev; // Previous comparator sample
   // Track enable and input quiet time
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enShadow <= 1'b0;
         disCnt <= 4'h0;
         quietCnt <= 4'hf;
         compPrev <= compIn;
      end else begin
         compPrev <= compIn;
         if (pready && pwrite && !pslverr && paddr == 8'h00) begin
            enShadow <= pwdata[0];
         end
         disCnt <= enShadow ? 4'h0 : (disCnt == 4'hf ? disCnt : disCnt + 4'h1);
         quietCnt <= (compIn != compPrev) ? 4'h0 : (quietCnt == 4'hf ? quietCnt : quietCnt + 4'h1);
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_trig_single_pulse: assert property (trigOut |=> !trigOut)
      else $error("trigger pulse longer than one cycle");
   a_trig_after_edge: assert property (trigOut |-> quietCnt >= 4'h1 && quietCnt <= 4'h6)
      else $error("trigger without recent input edge");
   a_quiet_disabled: assert property (disCnt >= 4'h6 |-> !trigOut)
      else $error("trigger while disabled");
   a_ready_wait_state: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
      else $error("ready not in second access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_ready_low_setup: assert property (psel && !penable |-> !pready)
      else $error("ready during setup cycle");
   a_err_unmapped: assert property (pready |-> pslverr == (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0))
      else $error("error flag does not match address");
   c_trig: cover property (trigOut);
   c_err: cover property (pready && pslverr);
   c_read: cover property (pready && !pwrite);
endmodule // qte_engine_checker
bind qte_engine qte_engine_checker #(.NCH(NCH)) u_qte_engine_checker (.core_clk(core_clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .compIn(compIn), .trigOut(trigOut));

// ### qte_comp_model.sv
// Model of the channel comparators feeding the engine.
// Assumes tasks are called just after a rising core clock edge.
`timescale 1ns/1ps
module qte_comp_model #(
   parameter NCH = 4
) (
   input wire core_clk, // Core clock
   output logic [NCH-1:0] compIn // Comparator levels
);
   initial compIn = '0;
   // One pulse on channel 0; other channels wander at random
   task automatic pulse(input int h, input int l);
      logic [31:0] r;
      r = $urandom;
      compIn <= {r[NCH-2:0], 1'b1};
      repeat (h) @(posedge core_clk);
      compIn[0] <= 1'b0; // Falling edge after width h
      repeat (l) @(posedge core_clk);
   endtask
endmodule // qte_comp_model

// ### qualified_trigger_engine_tb.sv
// Self-checking bench for the trigger engine.
// Assumes small limit parameters so every count stays short.
`timescale 1ns/1ps
`include "qte_regs.vh"
module qualified_trigger_engine_tb;
   logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00; // APB address
   logic [31:0] pwdata = 32'h0; // APB write data
   wire [31:0] prdata; // Read data
   wire pready, pslverr, trigOut; // Design outputs
   wire [3:0] compIn; // Comparator levels
   int n_errors = 0, cmp_count = 0, trigCnt = 0;
   logic [32:0] expQ[$]; // Expected {error, read data}
   always #4 core_clk = ~core_clk;
   qte_engine #(.NCH(4), .TMAX_CYC(40'd1000), .EV_MAX(24'd50)) u_qte_engine (.core_clk(core_clk),
      .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .compIn(compIn), .trigOut(trigOut));
   qte_comp_model #(.NCH(4)) u_qte_comp_model (.core_clk(core_clk), .compIn(compIn));
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Monitor: compare every APB answer with the oldest note
   always @(posedge core_clk) begin
      if (trigOut === 1'b1) trigCnt++;
      if (psel && penable && pready === 1'b1) begin
         logic [32:0] e;
         e = expQ.pop_front();
         chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
         if (!pwrite) chk("prdata", prdata, e[31:0]);
      end
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   // One APB transfer; waits for ready under a bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      expQ.push_back(e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_errors++;
         test_done();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk); // Never reassign psel in the same step
   endtask
   // Configure while idle, enable, then play pulses and count triggers
   task automatic run(input logic [1:0] m, input logic [2:0] q, input logic s, input int lim,
      input int h, input int np, input int exp);
      logic [31:0] c;
      c = {22'h0, 3'h0, s, q, m, 1'b0};
      apb(1'b1, `QTE_OFS_CTRL, 32'h0, 33'h0);
      apb(1'b1, `QTE_OFS_LIMA_LO, lim, 33'h0);
      apb(1'b1, `QTE_OFS_EVENTS, lim, 33'h0);
      apb(1'b1, `QTE_OFS_PATTERN, {30'h0, `QTE_PAT_H}, 33'h0);
      apb(1'b1, `QTE_OFS_CTRL, c | 32'h1, 33'h0);
      apb(1'b1, `QTE_OFS_EVENTS, 32'h7, 33'h0); // Ignored while enabled
      apb(0, `QTE_OFS_EVENTS, 0, {1'b0, lim});
      repeat (100) @(posedge core_clk);
      trigCnt = 0;
      repeat (np) u_qte_comp_model.pulse(h, 5);
      repeat (30) @(posedge core_clk);
   endtask
   initial begin
      void'($urandom(32'hf13b));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // Reset values, unmapped and read-only places
      apb(0, `QTE_OFS_CTRL, 0, {1'b0, `QTE_CTRL_RST});
      apb(0, `QTE_OFS_LIMA_LO, 0, 33'h4);
      apb(0, `QTE_OFS_EVENTS, 0, 33'h1);
      apb(1'b1, `QTE_OFS_STATUS, 32'hffff_ffff, 33'h0);
      apb(0, 8'h20, 0, {1'b1, 32'h0});
      apb(1'b1, 8'h22, 32'h1, {1'b1, 32'h0});
      $display("test registers done");
      run(`QTE_M_SINGLE, `QTE_Q_HOLD_E, 1'b1, 3, 5, 8, 0);
      chk("hold events", trigCnt, 2);
      run(`QTE_M_SINGLE, `QTE_Q_PW_GT, 1'b0, 10, 20, 4, 0);
      chk("pulse greater", trigCnt, 4);
      run(`QTE_M_SINGLE, `QTE_Q_PW_LT, 1'b0, 10, 5, 4, 0);
      chk("pulse less", trigCnt, 4);
      run(`QTE_M_SINGLE, `QTE_Q_PW_LT, 1'b0, 10, 20, 4, 0);
      chk("pulse less wide", trigCnt, 0);
      run(`QTE_M_SINGLE, `QTE_Q_INT_LT, 1'b1, 20, 5, 4, 0);
      chk("interval less", trigCnt, 3);
      run(`QTE_M_SINGLE, `QTE_Q_INT_GT, 1'b1, 5, 5, 4, 0);
      chk("interval greater", trigCnt, 3);
      run(`QTE_M_SINGLE, `QTE_Q_HOLD_T, 1'b1, 45, 5, 8, 0);
      chk("hold time", trigCnt, 2);
      run(`QTE_M_PATTERN, `QTE_Q_PW_GT, 1'b1, 10, 20, 4, 0);
      chk("pattern width", trigCnt, 4);
      run(`QTE_M_PATTERN, `QTE_Q_TBP_LT, 1'b1, 10, 5, 4, 0);
      chk("gap less", trigCnt, 3);
      run(`QTE_M_STATE, `QTE_Q_HOLD_E, 1'b1, 1, 5, 4, 0);
      chk("state index", trigCnt, 4);
      run(`QTE_M_TIME, `QTE_Q_HOLD_E, 1'b1, 0, 5, 4, 0);
      chk("time index", trigCnt, 3);
      $display("test qualifications done");
      test_done();
   end
   // Hang guard
   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      test_done();
   end
endmodule // qualified_trigger_engine_tb
